//--- verilog/crcs_top.sv
// crc engine registers and program memory scanner, top level
//
// How it works
// - data low write marks word full for the shifter
// - accumulator bytes read and write directly
// - shifter bytes read only, reset zero
// - xor bits 15..1 enable polynomial terms
// - xor bit zero always reads one
// - enable low resets scanner state machine
// - disabling keeps every other register content except the pending trigger
// - go fetches flash when crc ready
// - go clears once current passes end
// - interrupt management masks go during interrupts
// - burst stalls cpu; management bit picks priority
// - concurrent/triggered: management one suspends during interrupts
// - mode field selects; peek ignores management bit
// - busy shows fetch or crc ready
// - invalid when address beyond implemented memory
// - current address increments after each fetch
// - address writes ignored while go set
// - end address register bounds the scan
// - full shows unshifted data in data bytes
`default_nettype none
module crcs_top #(
  parameter logic [16:0] PFM_WORDS = 17'h04000
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic irq_active_in,
  input wire logic cpu_idle_in,
  input wire logic trigger_in,
  output crcs_pkg::crcs_flash_req_t flash_out,
  input wire logic [15:0] flash_data_in,
  input wire logic flash_ack_in,
  output logic cpu_stall_out
);
  import crcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // parameter check
  if (PFM_WORDS == 17'h00000 || PFM_WORDS > 17'h10000) begin : g_bad_size
    $error("program memory size out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] data_reg;
  logic [15:0] data_next;
  logic full_reg;
  logic full_next;
  logic [15:0] xor_reg;
  logic crc_en_reg;
  logic crc_go_reg;
  crcs_scan_ctl_t scan_reg;
  crcs_scan_ctl_t scan_next;
  logic [15:0] cur_reg;
  logic [15:0] cur_next;
  logic [15:0] end_reg;
  crcs_state_t state_reg;
  crcs_state_t state_next;
  crcs_flash_req_t flash_reg;
  crcs_flash_req_t flash_next;
  logic stall_reg;
  logic trig_old_reg;
  logic trig_pend_reg;
  logic [7:0] rdata_reg;
  logic [15:0] acc;
  logic [15:0] shift;
  logic empty;
  logic trig_sync;
  logic [15:0] xor_mask;

  //////////////////////////////////////////////////////////////////////////
  // register port decode
  logic wr_data_l, wr_data_h, wr_acc_l, wr_acc_h, wr_xor_l, wr_xor_h;
  logic wr_crc_ctl, wr_scan_ctl, wr_cur_l, wr_cur_h, wr_end_l, wr_end_h;
  assign wr_data_l = reg_wr_in && (reg_addr_in == CRCS_OFF_DATA_L);
  assign wr_data_h = reg_wr_in && (reg_addr_in == CRCS_OFF_DATA_H);
  assign wr_acc_l = reg_wr_in && (reg_addr_in == CRCS_OFF_ACC_L);
  assign wr_acc_h = reg_wr_in && (reg_addr_in == CRCS_OFF_ACC_H);
  assign wr_xor_l = reg_wr_in && (reg_addr_in == CRCS_OFF_XOR_L);
  assign wr_xor_h = reg_wr_in && (reg_addr_in == CRCS_OFF_XOR_H);
  assign wr_crc_ctl = reg_wr_in && (reg_addr_in == CRCS_OFF_CRC_CTL);
  assign wr_scan_ctl = reg_wr_in && (reg_addr_in == CRCS_OFF_SCAN_CTL);
  // address pairs are frozen while a scan is running
  assign wr_cur_l = reg_wr_in && (reg_addr_in == CRCS_OFF_CUR_L) && !scan_reg.go;
  assign wr_cur_h = reg_wr_in && (reg_addr_in == CRCS_OFF_CUR_H) && !scan_reg.go;
  assign wr_end_l = reg_wr_in && (reg_addr_in == CRCS_OFF_END_L) && !scan_reg.go;
  assign wr_end_h = reg_wr_in && (reg_addr_in == CRCS_OFF_END_H) && !scan_reg.go;

  //////////////////////////////////////////////////////////////////////////
  // crc engine
  logic take;
  logic crc_run;
  logic crc_ready;
  assign crc_run = crc_en_reg && crc_go_reg;
  // constant term of the polynomial is always fed back
  assign xor_mask = {xor_reg[15:1], 1'b1};
  // data bytes move into the shifter once it has drained
  assign take = full_reg && empty && crc_run;
  assign crc_ready = crc_run && !full_reg;

  crcs_crc_engine u_engine (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .run_in(crc_run),
    .xor_mask_in(xor_mask),
    .load_in(take),
    .load_word_in(data_reg),
    .acc_wr_lo_in(wr_acc_l),
    .acc_wr_hi_in(wr_acc_h),
    .acc_wdata_in(reg_wdata_in),
    .acc_out(acc),
    .shift_out(shift),
    .empty_out(empty)
  );

  //////////////////////////////////////////////////////////////////////////
  // trigger pin synchroniser
  crcs_sync2 #(.W(1)) u_trig_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(trigger_in),
    .sync_out(trig_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // scanner conditions
  logic irq_block;
  logic go_eff;
  logic past_end;
  logic invalid;
  logic mode_ok;
  logic start;
  logic fetch_done;
  logic go_clear;
  logic busy;
  logic trig_rise;
  // interrupts mask go only with management set and outside peek mode
  assign irq_block = scan_reg.interrupt_management && irq_active_in
    && (scan_reg.mode != CRCS_MODE_PEEK);
  assign go_eff = scan_reg.en && scan_reg.go && !irq_block;
  assign past_end = cur_reg > end_reg;
  assign invalid = {1'b0, cur_reg} >= PFM_WORDS;
  assign trig_rise = trig_sync && !trig_old_reg;
  // peek and triggered modes gate when a fetch may begin
  assign mode_ok = (scan_reg.mode == CRCS_MODE_CONC)
    || (scan_reg.mode == CRCS_MODE_BURST)
    || ((scan_reg.mode == CRCS_MODE_PEEK) && cpu_idle_in)
    || ((scan_reg.mode == CRCS_MODE_TRIG) && trig_pend_reg);
  assign start = go_eff && crc_ready && mode_ok && !past_end && !invalid
    && (state_reg == CRCS_ST_IDLE);
  assign fetch_done = (state_reg == CRCS_ST_FETCH) && flash_ack_in;
  assign go_clear = scan_reg.go && past_end && (state_reg == CRCS_ST_IDLE);
  assign busy = (state_reg == CRCS_ST_FETCH) || (go_eff && crc_ready);

  //////////////////////////////////////////////////////////////////////////
  // scanner state machine, reset by the enable bit
  always_comb begin
    state_next = state_reg;
    flash_next = flash_reg;
    case (state_reg)
      CRCS_ST_IDLE: begin
        if (start) begin
          state_next = CRCS_ST_FETCH;
          flash_next.req = 1'b1;
          flash_next.addr = cur_reg;
        end
      end
      CRCS_ST_FETCH: begin
        if (flash_ack_in) begin
          state_next = CRCS_ST_IDLE;
          flash_next.req = 1'b0;
        end
      end
      default: begin
        state_next = CRCS_ST_IDLE;
        flash_next.req = 1'b0;
      end
    endcase
    if (!scan_reg.en) begin
      state_next = CRCS_ST_IDLE;
      flash_next.req = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next values of data, address and control
  always_comb begin
    data_next = data_reg;
    if (wr_data_h) begin
      data_next[15:8] = reg_wdata_in;
    end
    if (wr_data_l) begin
      data_next[7:0] = reg_wdata_in;
    end
    // a fetched word is handed to the crc data bytes
    if (fetch_done) begin
      data_next = flash_data_in;
    end
    // a new word sets full even in the cycle the old one is taken
    full_next = wr_data_l || fetch_done || (full_reg && !take);
    cur_next = cur_reg;
    if (wr_cur_l) begin
      cur_next[7:0] = reg_wdata_in;
    end
    if (wr_cur_h) begin
      cur_next[15:8] = reg_wdata_in;
    end
    if (fetch_done) begin
      cur_next = cur_reg + CRCS_ADDR_STEP;
    end
    scan_next = scan_reg;
    if (go_clear) begin
      scan_next.go = 1'b0;
    end
    // software write wins so a fresh go is never lost; only the
    // stored bits change, the address pair is left alone
    if (wr_scan_ctl) begin
      scan_next.en = reg_wdata_in[CRCS_BIT_EN];
      scan_next.go = reg_wdata_in[CRCS_BIT_GO];
      scan_next.interrupt_management = reg_wdata_in[CRCS_BIT_INT_MGMT];
      scan_next.mode = crcs_mode_t'(reg_wdata_in[CRCS_MODE_LSB +: 2]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read map; unmapped index reads zero
  logic [7:0] rd_map [0:CRCS_NUM_REGS-1];
  assign rd_map[CRCS_OFF_DATA_L] = data_reg[7:0];
  assign rd_map[CRCS_OFF_DATA_H] = data_reg[15:8];
  assign rd_map[CRCS_OFF_ACC_L] = acc[7:0];
  assign rd_map[CRCS_OFF_ACC_H] = acc[15:8];
  assign rd_map[CRCS_OFF_SHIFT_L] = shift[7:0];
  assign rd_map[CRCS_OFF_SHIFT_H] = shift[15:8];
  assign rd_map[CRCS_OFF_XOR_L] = xor_mask[7:0];
  assign rd_map[CRCS_OFF_XOR_H] = xor_reg[15:8];
  assign rd_map[CRCS_OFF_CRC_CTL] = {crc_en_reg, crc_go_reg, !empty || full_reg,
    4'h0, full_reg};
  assign rd_map[CRCS_OFF_SCAN_CTL] = {scan_reg.en, scan_reg.go, busy, invalid,
    scan_reg.interrupt_management, 1'b0, scan_reg.mode};
  assign rd_map[CRCS_OFF_CUR_L] = cur_reg[7:0];
  assign rd_map[CRCS_OFF_CUR_H] = cur_reg[15:8];
  assign rd_map[CRCS_OFF_END_L] = end_reg[7:0];
  assign rd_map[CRCS_OFF_END_H] = end_reg[15:8];
  assign rd_map[4'hE] = CRCS_RST_BYTE;
  assign rd_map[4'hF] = CRCS_RST_BYTE;

  //////////////////////////////////////////////////////////////////////////
  // registers of the crc side
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      data_reg <= CRCS_RST_WORD;
      full_reg <= 1'b0;
      xor_reg <= CRCS_RST_XOR;
      crc_en_reg <= 1'b0;
      crc_go_reg <= 1'b0;
    end else if (ce_in) begin
      data_reg <= data_next;
      full_reg <= full_next;
      if (wr_xor_l) begin
        xor_reg[7:1] <= reg_wdata_in[7:1];
      end
      if (wr_xor_h) begin
        xor_reg[15:8] <= reg_wdata_in;
      end
      if (wr_crc_ctl) begin
        crc_en_reg <= reg_wdata_in[CRCS_BIT_EN];
        crc_go_reg <= reg_wdata_in[CRCS_BIT_GO];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers of the scanner side
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      scan_reg <= '0;
      cur_reg <= CRCS_RST_WORD;
      end_reg <= CRCS_RST_WORD;
      state_reg <= CRCS_ST_IDLE;
      flash_reg <= '0;
    end else if (ce_in) begin
      scan_reg <= scan_next;
      cur_reg <= cur_next;
      state_reg <= state_next;
      flash_reg <= flash_next;
      if (wr_end_l) begin
        end_reg[7:0] <= reg_wdata_in;
      end
      if (wr_end_h) begin
        end_reg[15:8] <= reg_wdata_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trigger capture, cpu stall and read data
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      trig_old_reg <= 1'b0;
      trig_pend_reg <= 1'b0;
      stall_reg <= 1'b0;
      rdata_reg <= CRCS_RST_BYTE;
    end else if (ce_in) begin
      trig_old_reg <= trig_sync;
      // a trigger arriving with the start is kept
      trig_pend_reg <= trig_rise || (trig_pend_reg && !start && scan_reg.en);
      // burst holds the cpu until the scan ends or an interrupt masks go
      stall_reg <= go_eff && (scan_reg.mode == CRCS_MODE_BURST);
      rdata_reg <= reg_rd_in ? rd_map[reg_addr_in] : CRCS_RST_BYTE;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign flash_out = flash_reg;
  assign cpu_stall_out = stall_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_load_full;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && wr_data_l) |=> full_reg;
  endproperty
  a_load_full: assert property (p_load_full)
    else $error("data low write did not mark the data bytes full");

  property p_acc_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && reg_rd_in && reg_addr_in == CRCS_OFF_ACC_H) |=>
      (reg_rdata_out == $past(acc[15:8]));
  endproperty
  a_acc_read: assert property (p_acc_read)
    else $error("accumulator high read mismatch");

  property p_shift_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && reg_rd_in && reg_addr_in == CRCS_OFF_SHIFT_L) |=>
      (reg_rdata_out == $past(shift[7:0]));
  endproperty
  a_shift_read: assert property (p_shift_read)
    else $error("shifter low read mismatch");

  property p_xor_one;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && reg_rd_in && reg_addr_in == CRCS_OFF_XOR_L) |=> reg_rdata_out[0];
  endproperty
  a_xor_one: assert property (p_xor_one)
    else $error("xor bit zero read as zero");

  property p_disable_idle;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && !scan_reg.en) |=> (state_reg == CRCS_ST_IDLE) && !flash_out.req;
  endproperty
  a_disable_idle: assert property (p_disable_idle)
    else $error("scanner active while disabled");

  property p_addr_locked;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && scan_reg.go && !fetch_done) |=> (cur_reg == $past(cur_reg));
  endproperty
  a_addr_locked: assert property (p_addr_locked)
    else $error("current address changed without a fetch");

  property p_go_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && go_clear && !wr_scan_ctl) |=> !scan_reg.go;
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("go not cleared past end address");

  property p_fetch_inc;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && fetch_done) |=> (cur_reg == $past(cur_reg) + CRCS_ADDR_STEP)
      && full_reg && (state_reg == CRCS_ST_IDLE);
  endproperty
  a_fetch_inc: assert property (p_fetch_inc)
    else $error("fetch did not advance the address");

  property p_irq_mask;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && irq_block && state_reg == CRCS_ST_IDLE) |=> !flash_out.req;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("fetch started during masked interrupt");

  property p_burst_stall;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && go_eff && scan_reg.mode == CRCS_MODE_BURST) |=> cpu_stall_out;
  endproperty
  a_burst_stall: assert property (p_burst_stall)
    else $error("cpu not stalled in burst");

  property p_invalid_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && reg_rd_in && reg_addr_in == CRCS_OFF_SCAN_CTL) |=>
      (reg_rdata_out[CRCS_BIT_INVALID] == ({1'b0, $past(cur_reg)} >= PFM_WORDS));
  endproperty
  a_invalid_read: assert property (p_invalid_read)
    else $error("invalid flag mismatch");
endmodule
`default_nettype wire

//--- verilog/crcs_pkg.sv
// package: register map, field layout, reset values and types of the crc scanner
`default_nettype none
package crcs_pkg;
  // register indices on the 4-bit byte register port
  localparam logic [3:0] CRCS_OFF_DATA_L = 4'h0;
  localparam logic [3:0] CRCS_OFF_DATA_H = 4'h1;
  localparam logic [3:0] CRCS_OFF_ACC_L = 4'h2;
  localparam logic [3:0] CRCS_OFF_ACC_H = 4'h3;
  localparam logic [3:0] CRCS_OFF_SHIFT_L = 4'h4;
  localparam logic [3:0] CRCS_OFF_SHIFT_H = 4'h5;
  localparam logic [3:0] CRCS_OFF_XOR_L = 4'h6;
  localparam logic [3:0] CRCS_OFF_XOR_H = 4'h7;
  localparam logic [3:0] CRCS_OFF_CRC_CTL = 4'h8;
  localparam logic [3:0] CRCS_OFF_SCAN_CTL = 4'h9;
  localparam logic [3:0] CRCS_OFF_CUR_L = 4'hA;
  localparam logic [3:0] CRCS_OFF_CUR_H = 4'hB;
  localparam logic [3:0] CRCS_OFF_END_L = 4'hC;
  localparam logic [3:0] CRCS_OFF_END_H = 4'hD;
  localparam int CRCS_NUM_REGS = 16;
  // bit positions in the control registers
  localparam int CRCS_BIT_EN = 7;
  localparam int CRCS_BIT_GO = 6;
  localparam int CRCS_BIT_BUSY = 5;
  localparam int CRCS_BIT_INVALID = 4;
  localparam int CRCS_BIT_INT_MGMT = 3;
  localparam int CRCS_BIT_FULL = 0;
  localparam int CRCS_MODE_LSB = 0;
  // reset values and address step per fetch
  localparam logic [7:0] CRCS_RST_BYTE = 8'h00;
  localparam logic [15:0] CRCS_RST_WORD = 16'h0000;
  localparam logic [15:0] CRCS_RST_XOR = 16'h0001;
  localparam logic [15:0] CRCS_ADDR_STEP = 16'h0001;
  // cycles to shift one data word through the engine
  localparam logic [4:0] CRCS_SHIFT_CYCLES = 5'h10;
  // access modes of the scanner
  typedef enum logic [1:0] {
    CRCS_MODE_CONC = 2'b00,
    CRCS_MODE_BURST = 2'b01,
    CRCS_MODE_PEEK = 2'b10,
    CRCS_MODE_TRIG = 2'b11
  } crcs_mode_t;
  // scanner states
  typedef enum logic [1:0] {
    CRCS_ST_IDLE = 2'b00,
    CRCS_ST_FETCH = 2'b01
  } crcs_state_t;
  // stored scanner control bits
  typedef struct packed {
    logic en;
    logic go;
    logic interrupt_management;
    crcs_mode_t mode;
  } crcs_scan_ctl_t;
  // request towards program flash
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } crcs_flash_req_t;
endpackage
`default_nettype wire

//--- verilog/crcs_sync2.sv
// two-flop synchroniser for levels from outside the clock domain
`default_nettype none
module crcs_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_in) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

//--- verilog/crcs_crc_engine.sv
// serial crc engine: shifter, bit counter and accumulator with xor feedback
`default_nettype none
module crcs_crc_engine (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic [15:0] xor_mask_in,
  input wire logic load_in,
  input wire logic [15:0] load_word_in,
  input wire logic acc_wr_lo_in,
  input wire logic acc_wr_hi_in,
  input wire logic [7:0] acc_wdata_in,
  output logic [15:0] acc_out,
  output logic [15:0] shift_out,
  output logic empty_out
);
  import crcs_pkg::*;
  logic [15:0] acc_reg;
  logic [15:0] shift_reg;
  logic [4:0] cnt_reg;
  logic step;
  logic fb;
  logic [15:0] acc_step;

  // one bit per cycle, msb first; feedback applies the enabled terms
  assign step = run_in && (cnt_reg != 5'h00);
  assign fb = acc_reg[15] ^ shift_reg[15];
  assign acc_step = {acc_reg[14:0], 1'b0} ^ (fb ? xor_mask_in : 16'h0000);
  assign empty_out = (cnt_reg == 5'h00);

  // software byte writes override the shifting result
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      acc_reg <= CRCS_RST_WORD;
      shift_reg <= CRCS_RST_WORD;
      cnt_reg <= 5'h00;
    end else if (ce_in) begin
      if (load_in) begin
        shift_reg <= load_word_in;
        cnt_reg <= CRCS_SHIFT_CYCLES;
      end else if (step) begin
        shift_reg <= {shift_reg[14:0], 1'b0};
        cnt_reg <= cnt_reg - 5'h01;
      end
      if (acc_wr_lo_in) begin
        acc_reg <= {(step ? acc_step[15:8] : acc_reg[15:8]), acc_wdata_in};
      end else if (acc_wr_hi_in) begin
        acc_reg <= {acc_wdata_in, (step ? acc_step[7:0] : acc_reg[7:0])};
      end else if (step) begin
        acc_reg <= acc_step;
      end
    end
  end

  assign acc_out = acc_reg;
  assign shift_out = shift_reg;
endmodule
`default_nettype wire

//--- dv/crcs_flash_model.sv
// flash stand-in: answers each fetch with a word built from its address
`default_nettype none
module crcs_flash_model #(
  parameter int WAIT = 6
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire crcs_pkg::crcs_flash_req_t req_in,
  output logic [15:0] data_out,
  output logic ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import crcs_pkg::*;
  int cnt;
  // wait while the request stands, then one ack with the word
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      ack_out <= 1'b0;
      data_out <= 16'h0000;
    end else if (req_in.req && !ack_out && cnt == WAIT) begin
      cnt <= 0;
      ack_out <= 1'b1;
      data_out <= req_in.addr ^ 16'hA5C3;
    end else begin
      cnt <= (req_in.req && !ack_out) ? cnt + 1 : 0;
      ack_out <= 1'b0;
      data_out <= ~data_out; // word inverted each cycle outside the ack
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// testbench: register sequences against the crc scanner
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import crcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq = 1'b0;
  logic idle = 1'b0;
  logic trig = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic [15:0] fdata;
  logic fack;
  logic stall;
  crcs_flash_req_t fl;
  int fails = 0;
  int checked = 0;
  //////////////////////////////////////////////////////////////////////
  // clock, design and flash
  always #10 clk = ~clk;
  crcs_top #(.PFM_WORDS(17'h00010)) uut (.clk_sys_in(clk), .rst_in(rst), .ce_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .irq_active_in(irq), .cpu_idle_in(idle), .trigger_in(trig),
    .flash_out(fl), .flash_data_in(fdata), .flash_ack_in(fack), .cpu_stall_out(stall));
  crcs_flash_model flash (.clk_sys_in(clk), .rst_in(rst), .req_in(fl), .data_out(fdata),
    .ack_out(fack));
  //////////////////////////////////////////////////////////////////////
  // bus tasks and comparison
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(a + 4'h1, d[15:8]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 4'h1, v[15:8]);
  endtask
  task automatic wait_go;
    logic [7:0] b;
    for (int i = 0; i < 400; i++) begin
      rd8(CRCS_OFF_SCAN_CTL, b);
      if (b[CRCS_BIT_GO] === 1'b0) break;
    end
    chk("go", 16'(b[CRCS_BIT_GO]), 16'h0000);
  endtask
  function automatic logic [15:0] crc(input logic [15:0] a, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) a = {a[14:0], 1'b0} ^ ((a[15] ^ d[i]) ? 16'h1021 : 16'h0);
    return a;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
  // main sequence
  initial begin
    logic [15:0] v;
    logic [15:0] e;
    logic [7:0] b;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd16(CRCS_OFF_SHIFT_L, v);
    chk("shift", v, 16'h0000);
    rd16(CRCS_OFF_XOR_L, v);
    chk("xor", v, 16'h0001);
    wr16(CRCS_OFF_ACC_L, 16'hC35A);
    wr16(CRCS_OFF_SHIFT_L, 16'hFFFF);
    rd16(CRCS_OFF_ACC_L, v);
    chk("acc", v, 16'hC35A);
    rd16(CRCS_OFF_SHIFT_L, v);
    chk("shift", v, 16'h0000);
    wr16(CRCS_OFF_XOR_L, 16'h1000);
    rd16(CRCS_OFF_XOR_L, v);
    chk("xor", v, 16'h1001);
    wr8(CRCS_OFF_XOR_L, 8'h20);
    wr16(CRCS_OFF_ACC_L, 16'h0000);
    // one word through the engine, held full while it is stopped
    wr8(CRCS_OFF_CRC_CTL, 8'h80);
    wr16(CRCS_OFF_DATA_H - 4'h1, 16'h1200);
    wr8(CRCS_OFF_DATA_L, 8'h34);
    rd8(CRCS_OFF_CRC_CTL, b);
    chk("full", 16'(b[CRCS_BIT_FULL]), 16'h0001);
    wr8(CRCS_OFF_CRC_CTL, 8'hC0);
    repeat (25) @(posedge clk);
    rd16(CRCS_OFF_ACC_L, v);
    chk("acc", v, crc(16'h0000, 16'h1234));
    rd8(CRCS_OFF_CRC_CTL, b);
    chk("full", 16'(b[CRCS_BIT_FULL]), 16'h0000);
    // concurrent scan of the last two words
    wr16(CRCS_OFF_ACC_L, 16'h0000);
    wr16(CRCS_OFF_CUR_L, 16'h000E);
    wr16(CRCS_OFF_END_L, 16'h000F);
    wr8(CRCS_OFF_SCAN_CTL, 8'hC0);
    wr8(CRCS_OFF_CUR_L, 8'h00);
    wait_go;
    rd16(CRCS_OFF_CUR_L, v);
    chk("cur", v, 16'h0010);
    rd8(CRCS_OFF_SCAN_CTL, b);
    chk("scan ctl", 16'(b & 8'hD0), 16'h0090);
    // the last fetched word still shifts after go has cleared
    repeat (40) @(posedge clk);
    rd16(CRCS_OFF_ACC_L, v);
    e = crc(crc(16'h0000, 16'h000E ^ 16'hA5C3), 16'h000F ^ 16'hA5C3);
    chk("acc", v, e);
    // burst held off by an interrupt, then disabled mid-scan
    wr16(CRCS_OFF_CUR_L, 16'h0000);
    irq <= 1'b1;
    wr8(CRCS_OFF_SCAN_CTL, 8'hC9);
    repeat (30) @(posedge clk);
    chk("stall", 16'(stall), 16'h0000);
    rd16(CRCS_OFF_CUR_L, v);
    chk("cur", v, 16'h0000);
    irq <= 1'b0;
    repeat (4) @(posedge clk);
    chk("stall", 16'(stall), 16'h0001);
    wr8(CRCS_OFF_SCAN_CTL, 8'h49);
    rd16(CRCS_OFF_CUR_L, e);
    repeat (40) @(posedge clk);
    chk("req", 16'(fl.req), 16'h0000);
    rd16(CRCS_OFF_CUR_L, v);
    chk("cur", v, e);
    wr8(CRCS_OFF_SCAN_CTL, 8'hC9);
    wait_go;
    rd16(CRCS_OFF_CUR_L, v);
    chk("cur", v, 16'h0010);
    // peek needs a free slot and ignores the interrupt setting
    wr16(CRCS_OFF_CUR_L, 16'h000F);
    irq <= 1'b1;
    wr8(CRCS_OFF_SCAN_CTL, 8'hCA);
    repeat (30) @(posedge clk);
    rd16(CRCS_OFF_CUR_L, v);
    chk("cur", v, 16'h000F);
    idle <= 1'b1;
    wait_go;
    rd16(CRCS_OFF_CUR_L, v);
    chk("cur", v, 16'h0010);
    irq <= 1'b0;
    // triggered: one fetch for each rising trigger edge
    wr16(CRCS_OFF_CUR_L, 16'h000E);
    wr8(CRCS_OFF_SCAN_CTL, 8'hC3);
    repeat (30) @(posedge clk);
    trig <= 1'b1;
    repeat (6) @(posedge clk);
    rd8(CRCS_OFF_SCAN_CTL, b);
    chk("busy", 16'(b[CRCS_BIT_BUSY]), 16'h0001);
    repeat (40) @(posedge clk);
    rd16(CRCS_OFF_CUR_L, v);
    chk("cur", v, 16'h000F);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    trig <= 1'b1;
    wait_go;
    print_verdict;
  end
endmodule
`default_nettype wire
